/* File: hw/reg_change_alu.sv */
`timescale 1ns/1ps

module reg_change_alu (
	input  wire logic                 MCLK,
	input  wire logic                 RESETN,
	input  wire logic                 CMD_VALID,
	input  wire rc_alu_pkg::cmd_type  CMD,
	output logic                      CMD_BAD,
	output rc_alu_pkg::state_type     STATE
);

	// ----------------------------------------
	// Architectural state
	// ----------------------------------------
	logic [15:0] accum_ff;
	logic [15:0] index_ff;
	logic        link_ff;
	logic        bad_ff;
	logic [15:0] nxt_accum;
	logic [15:0] nxt_index;
	logic        nxt_link;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic is_single(input rc_alu_pkg::op_type op);
		return op inside {rc_alu_pkg::rotate_accum_left, rc_alu_pkg::rotate_index_left,
			rc_alu_pkg::rotate_accum_right, rc_alu_pkg::rotate_index_right};
	endfunction

	function automatic logic is_long(input rc_alu_pkg::op_type op);
		return op inside {rc_alu_pkg::long_logical_left, rc_alu_pkg::long_logical_right,
			rc_alu_pkg::long_rotate_left, rc_alu_pkg::long_rotate_right};
	endfunction

	// Signed overflow of a +1 or -1 step: only the extreme values wrap
	function automatic logic wrap_up(input logic [15:0] v);
		return v == rc_alu_pkg::SIGN_MAX;
	endfunction

	function automatic logic wrap_down(input logic [15:0] v);
		return v == rc_alu_pkg::SIGN_MIN;
	endfunction

	rc_alu_pkg::op_type op;
	wire logic [4:0]    cnt;
	wire logic [3:0]    bno;
	wire logic          single_op;
	wire logic          long_op;
	wire logic          count_ok;
	wire logic          take;

	assign op        = CMD.op;
	assign cnt       = CMD.count;
	assign bno       = CMD.bit_no;
	assign single_op = is_single(op);
	assign long_op   = is_long(op);
	// Out-of-range counts are refused whole rather than wrapped: a partial shift is harder to spot
	assign count_ok  = (cnt >= rc_alu_pkg::COUNT_MIN)
		&& (cnt <= (single_op ? rc_alu_pkg::SINGLE_MAX : rc_alu_pkg::DOUBLE_MAX));
	assign take      = CMD_VALID && (!(single_op || long_op) || count_ok);

	// ----------------------------------------
	// Shift chain
	// ----------------------------------------
	wire logic        single_accum;
	wire logic        go_left;
	wire logic        rotate;
	wire logic [32:0] chain_in;
	wire logic [32:0] chain_out;
	wire logic [15:0] single_src;

	assign single_accum = op inside {rc_alu_pkg::rotate_accum_left, rc_alu_pkg::rotate_accum_right};
	assign single_src   = single_accum ? accum_ff : index_ff;
	assign go_left      = op inside {rc_alu_pkg::rotate_accum_left, rc_alu_pkg::rotate_index_left,
		rc_alu_pkg::long_logical_left, rc_alu_pkg::long_rotate_left};
	assign rotate       = !(op inside {rc_alu_pkg::long_logical_left, rc_alu_pkg::long_logical_right});

	// Single rotates use a 17-bit ring; link sits directly above the selected register so
	// the ring closes through link at bit 16 of a 17-bit slice
	wire logic [16:0] ring_in;
	wire logic [16:0] ring_out;
	logic      [16:0] ring_stage [0:8];

	assign ring_in       = {link_ff, single_src};
	assign ring_stage[0] = ring_in;

	genvar s;
	generate
		for (s = 0; s < 8; s++) begin : g_ring
			wire logic [16:0] moved;
			assign moved = go_left ? {ring_stage[s][15:0], ring_stage[s][16]}
				: {ring_stage[s][0], ring_stage[s][16:1]};
			assign ring_stage[s+1] = (5'(s) < cnt) ? moved : ring_stage[s];
		end
	endgenerate
	assign ring_out = ring_stage[8];

	// Chain order: link, accum, index (link at bit 32, index bit 0 at bit 0)
	assign chain_in = {link_ff, accum_ff, index_ff};

	chain_shifter u_chain (
		.chain_in  (chain_in),
		.count     (cnt),
		.go_left   (go_left),
		.rotate    (rotate),
		.chain_out (chain_out)
	);

	// ----------------------------------------
	// Arithmetic and bit helpers
	// ----------------------------------------
	wire logic [15:0] bit_mask;
	wire logic        accum_sel_bit;
	wire logic        index_sel_bit;
	wire logic [15:0] and_ax;
	wire logic [15:0] nor_ax;

	assign bit_mask      = rc_alu_pkg::WORD_ONE << bno;
	assign accum_sel_bit = accum_ff[bno];
	assign index_sel_bit = index_ff[bno];
	assign and_ax        = accum_ff & index_ff;
	assign nor_ax        = ~(accum_ff | index_ff);

	// ----------------------------------------
	// Next-state selection
	// ----------------------------------------
	always_comb begin
		nxt_accum = accum_ff;
		nxt_index = index_ff;
		nxt_link  = link_ff;
		unique case (op)
			rc_alu_pkg::rotate_accum_left, rc_alu_pkg::rotate_accum_right: begin
				{nxt_link, nxt_accum} = ring_out;
			end
			rc_alu_pkg::rotate_index_left, rc_alu_pkg::rotate_index_right: begin
				{nxt_link, nxt_index} = ring_out;
			end
			rc_alu_pkg::long_logical_left, rc_alu_pkg::long_logical_right,
			rc_alu_pkg::long_rotate_left, rc_alu_pkg::long_rotate_right: begin
				{nxt_link, nxt_accum, nxt_index} = chain_out;
			end
			rc_alu_pkg::accum_minus_one: nxt_accum = rc_alu_pkg::WORD_MINUS;
			rc_alu_pkg::accum_plus_one:  nxt_accum = rc_alu_pkg::WORD_ONE;
			rc_alu_pkg::accum_clear:     nxt_accum = rc_alu_pkg::WORD_ZERO;
			rc_alu_pkg::accum_ones_comp: nxt_accum = ~accum_ff;
			rc_alu_pkg::accum_twos_comp: nxt_accum = 16'(~accum_ff + rc_alu_pkg::WORD_ONE);
			rc_alu_pkg::accum_increment: begin
				nxt_accum = 16'(accum_ff + rc_alu_pkg::WORD_ONE);
				nxt_link  = link_ff | wrap_up(accum_ff);
			end
			rc_alu_pkg::accum_decrement: begin
				nxt_accum = 16'(accum_ff - rc_alu_pkg::WORD_ONE);
				nxt_link  = link_ff | wrap_down(accum_ff);
			end
			rc_alu_pkg::index_minus_one: nxt_index = rc_alu_pkg::WORD_MINUS;
			rc_alu_pkg::index_plus_one:  nxt_index = rc_alu_pkg::WORD_ONE;
			rc_alu_pkg::index_clear:     nxt_index = rc_alu_pkg::WORD_ZERO;
			rc_alu_pkg::index_ones_comp: nxt_index = ~index_ff;
			rc_alu_pkg::index_twos_comp: begin
				nxt_index = 16'(~index_ff + rc_alu_pkg::WORD_ONE);
				nxt_link  = link_ff | wrap_down(index_ff);
			end
			rc_alu_pkg::index_increment: begin
				nxt_index = 16'(index_ff + rc_alu_pkg::WORD_ONE);
				nxt_link  = link_ff | wrap_up(index_ff);
			end
			rc_alu_pkg::index_decrement: begin
				nxt_index = 16'(index_ff - rc_alu_pkg::WORD_ONE);
				nxt_link  = link_ff | wrap_down(index_ff);
			end
			rc_alu_pkg::accum_bit_set: begin
				nxt_accum = accum_ff | bit_mask;
				nxt_link  = accum_sel_bit;
			end
			rc_alu_pkg::accum_bit_clear: begin
				nxt_accum = accum_ff & ~bit_mask;
				nxt_link  = accum_sel_bit;
			end
			rc_alu_pkg::accum_bit_invert: begin
				nxt_accum = accum_ff ^ bit_mask;
				nxt_link  = accum_sel_bit;
			end
			rc_alu_pkg::index_bit_set: begin
				nxt_index = index_ff | bit_mask;
				nxt_link  = index_sel_bit;
			end
			rc_alu_pkg::index_bit_clear: begin
				nxt_index = index_ff & ~bit_mask;
				nxt_link  = index_sel_bit;
			end
			rc_alu_pkg::index_bit_invert: begin
				nxt_index = index_ff ^ bit_mask;
				nxt_link  = index_sel_bit;
			end
			rc_alu_pkg::accum_bit_test:     nxt_link = accum_sel_bit;
			rc_alu_pkg::index_bit_test:     nxt_link = index_sel_bit;
			rc_alu_pkg::link_set:           nxt_link = 1'b1;
			rc_alu_pkg::link_clear:         nxt_link = 1'b0;
			rc_alu_pkg::link_invert:        nxt_link = ~link_ff;
			rc_alu_pkg::accum_sign_to_link: nxt_link = accum_ff[15];
			rc_alu_pkg::index_sign_to_link: nxt_link = index_ff[15];
			rc_alu_pkg::accum_low_to_link:  nxt_link = accum_ff[0];
			rc_alu_pkg::index_low_to_link:  nxt_link = index_ff[0];
			rc_alu_pkg::accum_bit_to_link:  nxt_link = accum_sel_bit;
			rc_alu_pkg::index_bit_to_link:  nxt_link = index_sel_bit;
			rc_alu_pkg::both_clear: begin
				nxt_accum = rc_alu_pkg::WORD_ZERO;
				nxt_index = rc_alu_pkg::WORD_ZERO;
			end
			rc_alu_pkg::both_plus_one: begin
				nxt_accum = rc_alu_pkg::WORD_ONE;
				nxt_index = rc_alu_pkg::WORD_ONE;
			end
			rc_alu_pkg::both_minus_one: begin
				nxt_accum = rc_alu_pkg::WORD_MINUS;
				nxt_index = rc_alu_pkg::WORD_MINUS;
			end
			rc_alu_pkg::copy_accum_to_index: nxt_index = accum_ff;
			rc_alu_pkg::copy_index_to_accum: nxt_accum = index_ff;
			rc_alu_pkg::swap_registers: begin
				nxt_accum = index_ff;
				nxt_index = accum_ff;
			end
			rc_alu_pkg::and_into_accum: nxt_accum = and_ax;
			rc_alu_pkg::and_into_index: nxt_index = and_ax;
			rc_alu_pkg::nor_into_accum: nxt_accum = nor_ax;
			rc_alu_pkg::nor_into_index: nxt_index = nor_ax;
			rc_alu_pkg::ones_comp_accum_to_index: nxt_index = ~accum_ff;
			rc_alu_pkg::ones_comp_index_to_accum: nxt_accum = ~index_ff;
			rc_alu_pkg::negate_accum_to_index: begin
				nxt_index = 16'(~accum_ff + rc_alu_pkg::WORD_ONE);
				nxt_link  = link_ff | wrap_down(accum_ff);
			end
			rc_alu_pkg::negate_index_to_accum: begin
				nxt_accum = 16'(~index_ff + rc_alu_pkg::WORD_ONE);
				nxt_link  = link_ff | wrap_down(index_ff);
			end
			rc_alu_pkg::inc_accum_to_index: begin
				nxt_index = 16'(accum_ff + rc_alu_pkg::WORD_ONE);
				nxt_link  = link_ff | wrap_up(accum_ff);
			end
			rc_alu_pkg::inc_index_to_accum: begin
				nxt_accum = 16'(index_ff + rc_alu_pkg::WORD_ONE);
				nxt_link  = link_ff | wrap_up(index_ff);
			end
			rc_alu_pkg::dec_accum_to_index: begin
				nxt_index = 16'(accum_ff - rc_alu_pkg::WORD_ONE);
				nxt_link  = link_ff | wrap_down(accum_ff);
			end
			rc_alu_pkg::dec_index_to_accum: begin
				nxt_accum = 16'(index_ff - rc_alu_pkg::WORD_ONE);
				nxt_link  = link_ff | wrap_down(index_ff);
			end
			// The sequencer advances the program counter itself
			rc_alu_pkg::pc_plus_two_to_index: nxt_index = 16'(CMD.pc + rc_alu_pkg::PC_STEP);
			default: begin
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			accum_ff <= rc_alu_pkg::RESET_WORD;
			index_ff <= rc_alu_pkg::RESET_WORD;
			link_ff  <= 1'b0;
		end else if (take) begin
			accum_ff <= nxt_accum;
			index_ff <= nxt_index;
			link_ff  <= nxt_link;
		end
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			bad_ff <= 1'b0;
		end else begin
			bad_ff <= CMD_VALID && !take;
		end
	end

	assign STATE   = rc_alu_pkg::state_type'({accum_ff, index_ff, link_ff});
	assign CMD_BAD = bad_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	rotate_ring_a: assert property (@(posedge MCLK) disable iff (!RESETN)
		CMD_VALID && op == rc_alu_pkg::rotate_accum_left && cnt == 5'h01
		|=> accum_ff == {$past(accum_ff[14:0]), $past(link_ff)} && link_ff == $past(accum_ff[15]))
		else $error("rotate left ring broken");

	rotate_right_a: assert property (@(posedge MCLK) disable iff (!RESETN)
		CMD_VALID && op == rc_alu_pkg::rotate_index_right && cnt == 5'h01
		|=> index_ff == {$past(link_ff), $past(index_ff[15:1])} && link_ff == $past(index_ff[0]))
		else $error("rotate right ring broken");

	bad_count_a: assert property (@(posedge MCLK) disable iff (!RESETN)
		CMD_VALID && long_op && cnt > rc_alu_pkg::DOUBLE_MAX
		|=> CMD_BAD && $stable(accum_ff) && $stable(index_ff) && $stable(link_ff))
		else $error("bad count not refused");

	long_left_a: assert property (@(posedge MCLK) disable iff (!RESETN)
		CMD_VALID && op == rc_alu_pkg::long_logical_left && cnt == 5'h10
		|=> index_ff == rc_alu_pkg::WORD_ZERO && accum_ff == $past(index_ff) && link_ff == $past(accum_ff[0]))
		else $error("long logical left wrong");

	long_right_a: assert property (@(posedge MCLK) disable iff (!RESETN)
		CMD_VALID && op == rc_alu_pkg::long_logical_right && cnt == 5'h01
		|=> accum_ff == {1'b0, $past(accum_ff[15:1])}
			&& index_ff == {$past(accum_ff[0]), $past(index_ff[15:1])} && link_ff == $past(index_ff[0]))
		else $error("long logical right wrong");

	long_rot_a: assert property (@(posedge MCLK) disable iff (!RESETN)
		CMD_VALID && op == rc_alu_pkg::long_rotate_right && cnt == 5'h01
		|=> accum_ff[15] == $past(link_ff) && index_ff[15] == $past(accum_ff[0]) && link_ff == $past(index_ff[0]))
		else $error("long rotate right wrong");

	inc_wrap_a: assert property (@(posedge MCLK) disable iff (!RESETN)
		CMD_VALID && op == rc_alu_pkg::accum_increment && accum_ff == rc_alu_pkg::SIGN_MAX
		|=> link_ff && accum_ff == rc_alu_pkg::SIGN_MIN)
		else $error("increment overflow missed");

	bit_change_a: assert property (@(posedge MCLK) disable iff (!RESETN)
		CMD_VALID && op == rc_alu_pkg::index_bit_invert
		|=> link_ff == $past(index_sel_bit) && (index_ff ^ $past(index_ff)) == $past(bit_mask))
		else $error("bit invert wrong");

	swap_pair_a: assert property (@(posedge MCLK) disable iff (!RESETN)
		CMD_VALID && op == rc_alu_pkg::swap_registers
		|=> accum_ff == $past(index_ff) && index_ff == $past(accum_ff) && $stable(link_ff))
		else $error("swap wrong");

	pc_index_a: assert property (@(posedge MCLK) disable iff (!RESETN)
		CMD_VALID && op == rc_alu_pkg::pc_plus_two_to_index
		|=> index_ff == 16'($past(CMD.pc) + rc_alu_pkg::PC_STEP) && $stable(accum_ff))
		else $error("pc plus two wrong");

endmodule

/* File: hw/rc_alu_pkg.sv */
package rc_alu_pkg;

	// ----------------------------------------
	// Widths and constants
	// ----------------------------------------
	localparam int          DATA_W       = 16;
	localparam int          CNT_W        = 5;
	localparam int          BIT_W        = 4;
	localparam logic [15:0] RESET_WORD   = 16'h0000;
	localparam logic [15:0] WORD_ZERO    = 16'h0000;
	localparam logic [15:0] WORD_ONE     = 16'h0001;
	localparam logic [15:0] WORD_MINUS   = 16'hFFFF;
	localparam logic [15:0] PC_STEP      = 16'h0002;
	localparam logic [15:0] SIGN_MIN     = 16'h8000;
	localparam logic [15:0] SIGN_MAX     = 16'h7FFF;
	localparam logic [4:0]  SINGLE_MAX   = 5'h08;
	localparam logic [4:0]  DOUBLE_MAX   = 5'h10;
	localparam logic [4:0]  COUNT_MIN    = 5'h01;

	// ----------------------------------------
	// Operations
	// ----------------------------------------
	typedef enum logic [6:0] {
		op_nop,
		rotate_accum_left, rotate_index_left, rotate_accum_right, rotate_index_right,
		long_logical_left, long_logical_right, long_rotate_left, long_rotate_right,
		accum_minus_one, accum_plus_one, accum_ones_comp, accum_decrement,
		accum_increment, accum_twos_comp, accum_clear,
		accum_bit_set, accum_bit_clear, accum_bit_invert, accum_bit_test,
		index_minus_one, index_plus_one, index_ones_comp, index_decrement,
		index_increment, index_twos_comp, index_clear,
		index_bit_set, index_bit_clear, index_bit_invert, index_bit_test,
		link_set, link_clear, link_invert,
		accum_sign_to_link, index_sign_to_link, accum_low_to_link, index_low_to_link,
		accum_bit_to_link, index_bit_to_link,
		both_clear, both_plus_one, both_minus_one,
		copy_accum_to_index, copy_index_to_accum, swap_registers,
		and_into_accum, and_into_index, nor_into_accum, nor_into_index,
		ones_comp_accum_to_index, ones_comp_index_to_accum,
		negate_accum_to_index, negate_index_to_accum,
		inc_accum_to_index, inc_index_to_accum, pc_plus_two_to_index,
		dec_accum_to_index, dec_index_to_accum
	} op_type;

	typedef struct packed {
		op_type            op;
		logic [CNT_W-1:0]  count;
		logic [BIT_W-1:0]  bit_no;
		logic [15:0]       pc;
	} cmd_type;

	typedef struct packed {
		logic [15:0] accum;
		logic [15:0] index;
		logic        link_bit;
	} state_type;

endpackage

/* File: hw/chain_shifter.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Barrel result of n one-position steps on a 33-bit chain
// ----------------------------------------
module chain_shifter (
	input  wire logic [32:0] chain_in,
	input  wire logic [4:0]  count,
	input  wire logic        go_left,
	input  wire logic        rotate,
	output logic      [32:0] chain_out
);

	logic [32:0] stage [0:16];

	assign stage[0] = chain_in;

	// Step k repeats the one-position move only while k is below the count
	genvar k;
	generate
		for (k = 0; k < 16; k++) begin : g_step
			wire logic [32:0] moved;
			// Going right the link takes the low end; only a rotate refills the top of the accumulator
			assign moved = go_left ? {stage[k][31:0], rotate & stage[k][32]}
				: {stage[k][0], rotate & stage[k][32], stage[k][31:1]};
			assign stage[k+1] = (5'(k) < count) ? moved : stage[k];
		end
	endgenerate

	assign chain_out = stage[16];

endmodule

/* File: testbench/decoder_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Instruction decoder stand-in
// ----------------------------------------
module decoder_model (
	input  wire logic                go,
	input  wire rc_alu_pkg::cmd_type req,
	output logic                     CMD_VALID,
	output rc_alu_pkg::cmd_type      CMD
);
	logic [6:0] opn;
	logic       has_bit;

	assign opn       = req.op;
	assign has_bit   = (opn >= 7'h10 && opn <= 7'h13) || (opn >= 7'h1B && opn <= 7'h1E) || opn == 7'h26 || opn == 7'h27;
	assign CMD_VALID = go;
	// Idle cycles carry an inverted word, so a stale command never looks valid
	assign CMD       = !go ? rc_alu_pkg::cmd_type'(~req) :
	                   has_bit ? req : rc_alu_pkg::cmd_type'({req.op, req.count, 4'h0, req.pc});
endmodule

/* File: testbench/shift_and_register_change_alu_tb.sv */
`timescale 1ns/1ps

module shift_and_register_change_alu_tb;
	logic                  MCLK;
	logic                  RESETN;
	logic                  go;
	rc_alu_pkg::cmd_type   req;
	logic                  CMD_VALID;
	rc_alu_pkg::cmd_type   CMD;
	logic                  CMD_BAD;
	rc_alu_pkg::state_type STATE;
	rc_alu_pkg::state_type exp;
	rc_alu_pkg::cmd_type   pend;
	logic                  pv;
	logic [31:0]           seed = 32'h0000005E;
	logic [31:0]           r;
	int                    err_total = 0;
	int                    total_checks = 0;
	int                    i;
	int cop[29] = '{9,32,3,32,13,12,21,32,4,25,32,53,58,32,54,1,1,1,5,5,5,8,6,7,16,19,29,39,56};
	int ccn[29] = '{0,0,1,0,0,0,0,0,2,0,0,0,0,0,0,0,8,9,16,17,0,16,1,31,0,0,0,0,0};
	int cbt[29] = '{0,0,0,0,0,0,0,0,0,0,0,0,0,0,0,0,0,0,0,0,0,0,0,0,15,0,15,15,0};

	reg_change_alu DUT (.MCLK(MCLK), .RESETN(RESETN), .CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_BAD(CMD_BAD), .STATE(STATE));
	decoder_model partner (.go(go), .req(req), .CMD_VALID(CMD_VALID), .CMD(CMD));

	initial begin
		MCLK = 1'b0;
		forever #50 MCLK = ~MCLK;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic rc_alu_pkg::cmd_type mk(int o, int n, int b, logic [15:0] pc);
		return rc_alu_pkg::cmd_type'({7'(o), 5'(n), 4'(b), pc});
	endfunction

	// Stepwise reference, one position per loop pass
	function automatic rc_alu_pkg::state_type step(rc_alu_pkg::cmd_type c, rc_alu_pkg::state_type s, output logic bad);
		logic [15:0] a;
		logic [15:0] x;
		logic [15:0] b;
		logic        l;
		int          n;
		int          k;
		a = s.accum;
		x = s.index;
		l = s.link_bit;
		n = c.count;
		k = c.bit_no;
		b = 16'h0001 << k;
		bad = ((c.op >= 1 && c.op <= 4) && (n < 1 || n > 8)) || ((c.op >= 5 && c.op <= 8) && (n < 1 || n > 16));
		if (!bad) begin
			case (int'(c.op))
				1: repeat (n) {l, a} = {a, l};
				2: repeat (n) {l, x} = {x, l};
				3: repeat (n) {a, l} = {l, a};
				4: repeat (n) {x, l} = {l, x};
				5: repeat (n) {l, a, x} = {a, x, 1'b0};
				6: repeat (n) {a, x, l} = {1'b0, a, x};
				7: repeat (n) {l, a, x} = {a, x, l};
				8: repeat (n) {a, x, l} = {l, a, x};
				9: a = 16'hFFFF;
				10: a = 16'h0001;
				11: a = ~a;
				12: begin l |= (a == 16'h8000); a = a - 16'h0001; end
				13: begin l |= (a == 16'h7FFF); a = a + 16'h0001; end
				14: a = -a;
				15: a = 16'h0000;
				16: begin l = a[k]; a |= b; end
				17: begin l = a[k]; a &= ~b; end
				18: begin l = a[k]; a ^= b; end
				19: l = a[k];
				20: x = 16'hFFFF;
				21: x = 16'h0001;
				22: x = ~x;
				23: begin l |= (x == 16'h8000); x = x - 16'h0001; end
				24: begin l |= (x == 16'h7FFF); x = x + 16'h0001; end
				25: begin l |= (x == 16'h8000); x = -x; end
				26: x = 16'h0000;
				27: begin l = x[k]; x |= b; end
				28: begin l = x[k]; x &= ~b; end
				29: begin l = x[k]; x ^= b; end
				30: l = x[k];
				31: l = 1'b1;
				32: l = 1'b0;
				33: l = ~l;
				34: l = a[15];
				35: l = x[15];
				36: l = a[0];
				37: l = x[0];
				38: l = a[k];
				39: l = x[k];
				40: {a, x} = {16'h0000, 16'h0000};
				41: {a, x} = {16'h0001, 16'h0001};
				42: {a, x} = {16'hFFFF, 16'hFFFF};
				43: x = a;
				44: a = x;
				45: {a, x} = {x, a};
				46: a = a & x;
				47: x = a & x;
				48: a = ~(a | x);
				49: x = ~(a | x);
				50: x = ~a;
				51: a = ~x;
				52: begin l |= (a == 16'h8000); x = -a; end
				53: begin l |= (x == 16'h8000); a = -x; end
				54: begin l |= (a == 16'h7FFF); x = a + 16'h0001; end
				55: begin l |= (x == 16'h7FFF); a = x + 16'h0001; end
				56: x = c.pc + 16'h0002;
				57: begin l |= (a == 16'h8000); x = a - 16'h0001; end
				58: begin l |= (x == 16'h8000); a = x - 16'h0001; end
				default: ;
			endcase
		end
		return rc_alu_pkg::state_type'({a, x, l});
	endfunction

	task check(string nm, logic [32:0] seen, logic [32:0] want);
		total_checks++;
		if (seen !== want) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, want, seen);
		end
	endtask

	// Drive one slot; the previous slot's command was taken at this edge
	task issue(rc_alu_pkg::cmd_type c, logic v);
		logic eb;
		int   o;
		@(posedge MCLK);
		go <= v;
		req <= c;
		#1;
		eb = 1'b0;
		o = int'(pend.op);
		if (pv) exp = step(pend, exp, eb);
		if (!pv || o == 0) check("hold", STATE, exp);
		else if (o < 5) check("rotate", STATE, exp);
		else if (o < 9) check("long shift", STATE, exp);
		else if (o < 16 || (o > 19 && o < 27)) check("load inc", STATE, exp);
		else if (o < 31) check("bit change", STATE, exp);
		else if (o < 34) check("link op", STATE, exp);
		else if (o < 40) check("to link", STATE, exp);
		else if (o < 43) check("both load", STATE, exp);
		else if (o < 46) check("copy swap", STATE, exp);
		else if (o < 50) check("and nor", STATE, exp);
		else if (o < 54) check("cross comp", STATE, exp);
		else if (o == 56) check("pc to index", STATE, exp);
		else check("cross inc", STATE, exp);
		check("refused", {32'h00000000, CMD_BAD}, {32'h00000000, eb});
		pend = c;
		pv = v;
	endtask

	task print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial begin
		repeat (8000) @(posedge MCLK);
		err_total++;
		print_verdict();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		RESETN = 1'b0;
		go = 1'b0;
		req = '0;
		exp = '0;
		pend = '0;
		pv = 1'b0;
		repeat (10) @(posedge MCLK);
		RESETN <= 1'b1;
		for (i = 0; i < 29; i++) issue(mk(cop[i], ccn[i], cbt[i], 16'hFFFF), 1'b1);
		for (i = 0; i < 59; i++) issue(mk(i, 2, rnd(), 16'(rnd())), 1'b1);
		for (i = 0; i < 1500; i++) begin
			r = rnd();
			issue(mk(r % 59, (r >> 8) % 18, r >> 16, 16'(rnd())), (r >> 24) % 8 != 0);
		end
		// Reset in mid-run, with a command pending that must be lost
		issue(mk(42, 0, 0, 16'h0000), 1'b1);
		@(posedge MCLK);
		RESETN <= 1'b0;
		req <= mk(41, 0, 0, 16'h0000);
		#1;
		check("reset", STATE, 33'h000000000);
		repeat (9) @(posedge MCLK);
		RESETN <= 1'b1;
		go <= 1'b0;
		exp = '0;
		pv = 1'b0;
		for (i = 0; i < 500; i++) begin
			r = rnd();
			issue(mk(r % 59, (r >> 8) % 18, r >> 16, 16'(rnd())), (r >> 24) % 4 != 0);
		end
		issue(mk(0, 0, 0, 16'h0000), 1'b0);
		issue(mk(0, 0, 0, 16'h0000), 1'b0);
		print_verdict();
	end
endmodule
